/* File: gpx_port.sv */
`default_nettype none
// How it works
// [R1] Eight pins, each set to input or output by its own direction bit.
// [R2] Reset clears direction and latch and sets every input-enable bit, so all pins are inputs.
// [R3] A pin whose direction bit is 1 is driven from its latch bit, whatever input-enable says.
// [R4] Direction 0 with input-enable 1 makes a digital input whose level reaches the read path.
// [R5] Direction 0 with input-enable 0 shuts the digital path and frees the pin for the converter.
// [R6] A data read gives latch for outputs, pin level for digital inputs, zero for analog pins.
// [R7] Digital input pins also feed their level to the interrupt and wakeup inputs.
// [R8] A bit operation writes back the read value of all bits, so input latches may take pin levels.
// [R9] Software never sets output direction on a pin used as an analog input.
// [R10] Software avoids port writes and nearby toggling while a conversion runs.
// [R11] A register write and the pin drive it causes both land on the edge that completes the write.
module gpx_port (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // write address channel
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [gpx_pkg::ADDR_W-1:0] s_axi_awaddr,
    // write data channel
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [gpx_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // write response channel
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // read address channel
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [gpx_pkg::ADDR_W-1:0] s_axi_araddr,
    // read data channel
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [gpx_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // port pins
    input wire logic [gpx_pkg::PORT_W-1:0] port_pins_in,
    output logic [gpx_pkg::PORT_W-1:0] port_pins_out,
    output logic [gpx_pkg::PORT_W-1:0] port_pins_oe,
    // towards interrupt, wakeup and converter
    output logic [gpx_pkg::PORT_W-1:0] wakeup_level,
    output logic [gpx_pkg::PORT_W-1:0] analog_channel_pins
);
    import gpx_pkg::*;

    // ---------------------------------------------------------------
    // pin input synchroniser
    // ---------------------------------------------------------------
    logic [PORT_W-1:0] sync1_reg, sync2_reg, sync3_reg, pin_level_reg, pin_level_next;

    // a change only counts once the last two stages agree
    always_comb begin
        for (int i = 0; i < PORT_W; i++) begin
            pin_level_next[i] = (sync2_reg[i] == sync3_reg[i]) ? sync3_reg[i] : pin_level_reg[i];
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
            pin_level_reg <= '0;
        end else begin
            sync1_reg <= port_pins_in;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            pin_level_reg <= pin_level_next;
        end
    end

    // ---------------------------------------------------------------
    // port registers
    // ---------------------------------------------------------------
    logic [PORT_W-1:0] latch_reg, latch_next, dir_reg, dir_next, ien_reg, ien_next;
    logic [PORT_W-1:0] read_value, wake_next, analog_next;
    logic [PORT_W-1:0] wakeup_reg, analog_reg;
    logic do_write, wr_lane0, wr_latch, wr_dir, wr_ien, wr_bitop, addr_ok;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [DATA_W-1:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic [2:0] bit_idx;
    logic [1:0] bit_op;

    // per-bit read mux
    // [R6] read value mux
    // [R4] input path enable
    // [R5] analog reads zero
    assign read_value = (dir_reg & latch_reg) | (~dir_reg & ien_reg & pin_level_reg);

    assign bit_idx = w_data_reg[BITOP_IDX_LSB +: 3];
    assign bit_op = w_data_reg[BITOP_OP_LSB +: 2];
    // a misaligned or unmapped address must not land on a register it aliases
    assign wr_lane0 = do_write && w_strb_reg[0] && addr_ok;
    assign wr_latch = wr_lane0 && aw_addr_reg[ADDR_W-1:2] == LATCH_IDX[ADDR_W-3:0];
    assign wr_dir = wr_lane0 && aw_addr_reg[ADDR_W-1:2] == DIR_IDX[ADDR_W-3:0];
    assign wr_ien = wr_lane0 && aw_addr_reg[ADDR_W-1:2] == IEN_IDX[ADDR_W-3:0];
    assign wr_bitop = wr_lane0 && aw_addr_reg[ADDR_W-1:2] == BITOP_IDX[ADDR_W-3:0];

    // register updates; pins follow straight from these flops
    always_comb begin
        latch_next = latch_reg;
        dir_next = dir_reg;
        ien_next = ien_reg;
        // [R11] write lands at once
        if (wr_latch) latch_next = w_data_reg[PORT_W-1:0];
        if (wr_dir) dir_next = w_data_reg[PORT_W-1:0];
        if (wr_ien) ien_next = w_data_reg[PORT_W-1:0];
        // [R8] whole read value written back
        if (wr_bitop) begin
            latch_next = read_value;
            unique case (bit_op)
                BITOP_SET: latch_next[bit_idx] = 1'b1;
                BITOP_CLR: latch_next[bit_idx] = 1'b0;
                BITOP_TGL: latch_next[bit_idx] = ~read_value[bit_idx];
                default: latch_next = read_value;
            endcase
        end
        // [R7] digital inputs feed wakeup
        wake_next = pin_level_reg & ~dir_reg & ien_reg;
        // [R5] analog pins freed
        analog_next = ~dir_reg & ~ien_reg;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        // [R2] all pins start as inputs
        if (!resetn) begin
            latch_reg <= LATCH_RST;
            dir_reg <= DIR_RST;
            ien_reg <= IEN_RST;
            wakeup_reg <= '0;
            analog_reg <= '0;
        end else begin
            latch_reg <= latch_next;
            dir_reg <= dir_next;
            ien_reg <= ien_next;
            wakeup_reg <= wake_next;
            analog_reg <= analog_next;
        end
    end

    // [R1] direction bit drives enable
    // [R3] output from latch
    assign port_pins_out = latch_reg;
    assign port_pins_oe = dir_reg;
    assign wakeup_level = wakeup_reg;
    assign analog_channel_pins = analog_reg;

    // ---------------------------------------------------------------
    // bus slave
    // ---------------------------------------------------------------
    logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
    logic [ADDR_W-1:0] aw_addr_next;
    logic [DATA_W-1:0] w_data_next, rdata_next;
    logic [3:0] w_strb_next;
    logic awready_reg, awready_next, wready_reg, wready_next, bvalid_reg, bvalid_next;
    logic arready_reg, arready_next, rvalid_reg, rvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [DATA_W-1:0] rdata_reg;

    assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
    assign addr_ok = aw_addr_reg == LATCH_ADDR || aw_addr_reg == DIR_ADDR
        || aw_addr_reg == IEN_ADDR || aw_addr_reg == BITOP_ADDR;

    // address and data taken in either order; response after both
    always_comb begin
        aw_held_next = aw_held_reg;
        w_held_next = w_held_reg;
        aw_addr_next = aw_addr_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        arready_next = arready_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (s_axi_awvalid && awready_reg) begin
            aw_held_next = 1'b1;
            aw_addr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_reg) begin
            w_held_next = 1'b1;
            w_data_next = s_axi_wdata;
            w_strb_next = s_axi_wstrb;
        end
        if (do_write) begin
            aw_held_next = 1'b0;
            w_held_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = addr_ok ? RESP_OKAY : RESP_SLVERR;
        end
        if (bvalid_reg && s_axi_bready) bvalid_next = 1'b0;
        // one read outstanding; unmapped reads return zero with an error
        if (s_axi_arvalid && arready_reg) begin
            rvalid_next = 1'b1;
            rresp_next = RESP_OKAY;
            if (s_axi_araddr == LATCH_ADDR) rdata_next = {24'h000000, read_value};
            else if (s_axi_araddr == DIR_ADDR) rdata_next = {24'h000000, dir_reg};
            else if (s_axi_araddr == IEN_ADDR) rdata_next = {24'h000000, ien_reg};
            else if (s_axi_araddr == BITOP_ADDR) rdata_next = 32'h00000000;
            else begin
                rdata_next = 32'h00000000;
                rresp_next = RESP_SLVERR;
            end
        end
        if (rvalid_reg && s_axi_rready) rvalid_next = 1'b0;
        awready_next = !aw_held_next && !bvalid_next;
        wready_next = !w_held_next && !bvalid_next;
        arready_next = !rvalid_next;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
        end else begin
            aw_held_reg <= aw_held_next;
            w_held_reg <= w_held_next;
            aw_addr_reg <= aw_addr_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence s_aw_taken;
        s_axi_awvalid && s_axi_awready;
    endsequence
    sequence s_w_taken;
        s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    a_reset_state: assert property ($rose(resetn) |-> dir_reg == DIR_RST // [R2]
        && latch_reg == LATCH_RST && ien_reg == IEN_RST && !s_axi_awready && !s_axi_bvalid)
        else $error("registers not at reset values");
    a_dir_write: assert property (wr_dir |=> port_pins_oe == $past(w_data_reg[7:0])) // [R1]
        else $error("direction write not on pins");
    a_latch_drive: assert property (wr_latch |=> port_pins_out == $past(w_data_reg[7:0])) // [R11]
        else $error("latch write not on pins in one edge");
    a_read_mux: assert property (s_ar_taken ##0 s_axi_araddr == LATCH_ADDR |=> // [R6]
        s_axi_rdata[7:0] == (($past(dir_reg) & $past(latch_reg))
        | (~$past(dir_reg) & $past(ien_reg) & $past(pin_level_reg))))
        else $error("data read value wrong");
    a_wake_route: assert property (##1 wakeup_level == // [R7]
        ($past(pin_level_reg) & ~$past(dir_reg) & $past(ien_reg)))
        else $error("wakeup level not routed");
    a_analog_free: assert property (##1 analog_channel_pins == // [R5]
        (~$past(dir_reg) & ~$past(ien_reg)))
        else $error("analog release wrong");
    a_bitop_rmw: assert property (wr_bitop |=> // [R8]
        ((latch_reg ^ $past(read_value)) & ~(8'h01 << $past(bit_idx))) == 8'h00)
        else $error("bit operation lost read value");
    a_write_resp: assert property (s_aw_taken ##0 s_w_taken |-> ##2 s_axi_bvalid) // [R11]
        else $error("write response late");
    a_read_resp: assert property (s_ar_taken |=> s_axi_rvalid[*1] ##0 !s_axi_arready) // [R6]
        else $error("read answer late");
endmodule // gpx_port
`default_nettype wire

/* File: gpx_pkg.sv */
`default_nettype none
package gpx_pkg;
    // ---------------------------------------------------------------
    // bus geometry
    // ---------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int PORT_W = 8;
    // ---------------------------------------------------------------
    // register indices, byte address is four times the index
    // ---------------------------------------------------------------
    localparam logic [ADDR_W-1:0] LATCH_IDX = 16'h0007;
    localparam logic [ADDR_W-1:0] DIR_IDX = 16'h0f9d;
    localparam logic [ADDR_W-1:0] IEN_IDX = 16'h0f9e;
    localparam logic [ADDR_W-1:0] BITOP_IDX = 16'h0010;
    localparam logic [ADDR_W-1:0] LATCH_ADDR = LATCH_IDX << 2;
    localparam logic [ADDR_W-1:0] DIR_ADDR = DIR_IDX << 2;
    localparam logic [ADDR_W-1:0] IEN_ADDR = IEN_IDX << 2;
    localparam logic [ADDR_W-1:0] BITOP_ADDR = BITOP_IDX << 2;
    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [PORT_W-1:0] LATCH_RST = 8'h00;
    localparam logic [PORT_W-1:0] DIR_RST = 8'h00;
    localparam logic [PORT_W-1:0] IEN_RST = 8'hff;
    // ---------------------------------------------------------------
    // bit operation register fields
    // ---------------------------------------------------------------
    localparam int BITOP_IDX_LSB = 0;
    localparam int BITOP_OP_LSB = 4;
    localparam logic [1:0] BITOP_SET = 2'h1;
    localparam logic [1:0] BITOP_CLR = 2'h2;
    localparam logic [1:0] BITOP_TGL = 2'h3;
    // ---------------------------------------------------------------
    // responses
    // ---------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

/* File: gpx_pin_model.sv */
`default_nettype none
module gpx_pin_model
    import gpx_pkg::*;
(
    // design side of the pads
    input wire logic [gpx_pkg::PORT_W-1:0] pin_out,
    input wire logic [gpx_pkg::PORT_W-1:0] pin_oe,
    // board side
    input wire logic [gpx_pkg::PORT_W-1:0] ext_level,
    output logic [gpx_pkg::PORT_W-1:0] pin_level
);
    // ---------------------------------------------------------------
    // pad resolution
    // ---------------------------------------------------------------
    // board never fights a driven pad
    // a driven pad wins; the board only sets undriven pads, so no clash is modelled
    assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // gpx_pin_model
`default_nettype wire

/* File: gpx_port_bench.sv */
`default_nettype none
module gpx_port_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import gpx_pkg::*;
    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    logic ref_clk = 1'b0, resetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [3:0] wstrb = 4'h0;
    logic [1:0] bresp, rresp, resp;
    logic [7:0] ext = 8'h3c, pin_in, pin_out, pin_oe, wake, ana;
    logic [31:0] rd;
    int n_mismatch = 0, checked = 0;
    always #10 ref_clk = ~ref_clk;
    gpx_port dut (.ref_clk(ref_clk), .resetn(resetn), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .port_pins_in(pin_in), .port_pins_out(pin_out),
        .port_pins_oe(pin_oe), .wakeup_level(wake), .analog_channel_pins(ana));
    gpx_pin_model pads (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_level(pin_in));
    // ---------------------------------------------------------------
    // bus tasks
    // ---------------------------------------------------------------
    // wide enough for read data joined with its response code
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // both channels offered together, each dropped once taken
    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge ref_clk);
        awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; wstrb <= s; bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge ref_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                resp = bresp;
                bready <= 1'b0;
                break;
            end
        end
        if (n == 50) chk(32'h1, 32'h0);
    endtask
    task automatic rd_reg(input logic [15:0] a);
        int n;
        @(posedge ref_clk);
        arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge ref_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                rd = rdata;
                resp = rresp;
                rready <= 1'b0;
                break;
            end
        end
        if (n == 50) chk(32'h1, 32'h0);
    endtask
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset;
        rd_reg(DIR_ADDR); chk(rd, 32'h00);
        rd_reg(IEN_ADDR); chk(rd, 32'hff);
        chk({pin_oe, pin_out, ana}, 24'h0);
        rd_reg(LATCH_ADDR); chk(rd, {24'h0, ext});
        chk(wake, ext);
        $display("test reset done");
    endtask
    task automatic t_modes;
        wr(DIR_ADDR, 32'hffff_ff0f, 4'h1); chk(pin_oe, 8'h0f);
        wr(LATCH_ADDR, 32'h0000_00a5, 4'h1); chk(pin_out, 8'ha5);
        rd_reg(LATCH_ADDR); chk(rd, 32'h35);
        // upper pins become analog after direction is already clear
        // analog pins keep direction clear
        wr(IEN_ADDR, 32'h0000_0000, 4'h1); repeat (3) @(posedge ref_clk);
        chk({pin_oe, pin_out, ana, wake}, 32'h0fa5_f000);
        rd_reg(LATCH_ADDR); chk(rd, 32'h05);
        $display("test modes done");
    endtask
    task automatic t_bitop;
        logic [1:0] op[4] = '{BITOP_SET, BITOP_CLR, BITOP_TGL, 2'h0};
        logic [2:0] bit_no[4] = '{3'd6, 3'd0, 3'd2, 3'd1};
        logic [7:0] exp_out[4] = '{8'h75, 8'h34, 8'h30, 8'h30};
        wr(IEN_ADDR, 32'h30, 4'h1); repeat (8) @(posedge ref_clk);
        for (int i = 0; i < 4; i++) begin
            wr(BITOP_ADDR, {26'h0, op[i], 1'b0, bit_no[i]}, 4'h1);
            chk(pin_out, exp_out[i]);
        end
        rd_reg(BITOP_ADDR); chk(rd, 32'h0);
        $display("test bit operations done");
    endtask
    task automatic t_refuse;
        wr(16'h0100, 32'h1, 4'h1); chk(resp, RESP_SLVERR);
        rd_reg(16'h0100); chk({rd, resp}, {32'h0, RESP_SLVERR});
        wr(DIR_ADDR, 32'hf0, 4'h0); chk({resp, pin_oe}, {RESP_OKAY, 8'h0f});
        rd_reg(DIR_ADDR); chk({rd, resp}, {32'h0f, RESP_OKAY});
        // pin change reaches wakeup after the filter delay
        ext <= 8'h1c; repeat (8) @(posedge ref_clk); chk(wake, 8'h10);
        $display("test refusals done");
    endtask
    // ---------------------------------------------------------------
    // sequence and verdict
    // ---------------------------------------------------------------
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (10) @(posedge ref_clk);
        t_reset();
        t_modes();
        t_bitop();
        t_refuse();
        close_out();
    end
    // whole run is about a hundred cycles; this allows fifty times that
    initial begin
        #100000;
        n_mismatch++;
        close_out();
    end
endmodule // gpx_port_bench
`default_nettype wire
